// >>> src/cmc_pkg.sv
package cmc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CMC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CMC_ADDR_CMP = 8'h04;
  localparam logic [7:0] CMC_ADDR_DREF = 8'h08;
  localparam logic [7:0] CMC_ADDR_CMD = 8'h0c;
  localparam logic [7:0] CMC_ADDR_STAT = 8'h10;
  localparam logic [7:0] CMC_ADDR_CFG = 8'h14;
  localparam logic [7:0] CMC_ADDR_CONS = 8'h18;
  localparam logic [7:0] CMC_ADDR_WIN = 8'h1c;
  localparam logic [7:0] CMC_ADDR_TRIDX = 8'h20;
  localparam logic [7:0] CMC_ADDR_TRDAT = 8'h24;
  localparam logic [7:0] CMC_ADDR_CNT = 8'h28;
  // ==========================================================
  // ctrl fields
  localparam int CMC_C_TRACE = 0;
  localparam int CMC_C_WRAP = 1;
  localparam int CMC_C_ACMP = 2;
  localparam int CMC_C_ACONT = 3;
  localparam int CMC_C_DCMP = 4;
  localparam int CMC_C_STEP = 5;
  localparam int CMC_C_SVC = 6;
  localparam int CMC_C_SRC_LO = 8;
  localparam int CMC_C_VIRT = 11;
  localparam int CMC_C_MCK_LO = 12;
  // cmd bits
  localparam int CMC_K_START = 0;
  localparam int CMC_K_STOP = 1;
  localparam int CMC_K_ULOAD = 2;
  localparam int CMC_K_PLOAD = 3;
  localparam int CMC_K_PGUP = 4;
  localparam int CMC_K_PGDN = 5;
  localparam int CMC_K_NORMAL = 6;
  localparam int CMC_K_SVCRATE = 7;
  // cfg fields
  localparam int CMC_G_AUTO = 0;
  localparam int CMC_G_CLEAR = 1;
  localparam int CMC_G_DISPM = 2;
  localparam int CMC_G_UNIT_LO = 4;
  localparam int CMC_UNIT_W = 12;
  localparam logic [31:0] CMC_CFG_RST = 32'h0000_0001;
  localparam logic [31:0] CMC_CONS_RST = 32'h0000_3210;
  localparam int CMC_PK_MAXADDR = 2;
  localparam logic [31:0] CMC_WIN_STEP = 32'h0000_0080;
  localparam int CMC_NCONS = 4;
  localparam int CMC_ADDR_W = 4;
  typedef enum logic [2:0]
  {
    CMC_SRC_ANY, CMC_SRC_IC, CMC_SRC_STOR, CMC_SRC_IO, CMC_SRC_UWORD, CMC_SRC_LOCAL
  } cmc_src_t;
  typedef enum logic [2:0]
  {
    CMC_MCK_NORMAL, CMC_MCK_HARD, CMC_MCK_NORETRY, CMC_MCK_DISABLE, CMC_MCK_LOGSTOP
  } cmc_mck_t;
  typedef struct packed
  {
    logic valid;
    cmc_src_t src;
    logic virt;
    logic [31:0] addr;
    logic [31:0] data;
  } cmc_ref_t;
  typedef struct packed
  {
    logic start;
    logic ok;
    logic fail;
    logic [7:0] code;
  } cmc_load_t;
endpackage

// >>> src/cmc_top.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module cmc_top
  import cmc_pkg::*;
#(
  parameter int TRACE_DEPTH = 168
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cmc_ref_t cpu_ref,
  input wire logic insn_done,
  input wire logic intr_pending,
  input wire logic intr_taken,
  input wire cmc_load_t sp_load,
  input wire cmc_load_t cpu_load,
  input wire logic [CMC_NCONS-1:0] cons_ok,
  output logic cpu_run_ff,
  output logic take_intr_ff,
  output logic full_reset_ff,
  output logic keep_tod_reset_ff,
  output logic cpu_load_req_ff,
  output logic prog_load_req_ff,
  output logic prog_load_clear_ff,
  output logic [CMC_UNIT_W-1:0] prog_load_unit_ff,
  output logic [2:0] mck_action_ff,
  output logic [1:0] primary_cons_ff
);
  localparam int TW = $clog2(TRACE_DEPTH);
  localparam logic [TW-1:0] TLAST = TW'(TRACE_DEPTH - 1);

  // ==========================================================
  // apb slave, zero wait state
  logic wr, rd;
  logic src_ok, cmp_hit, data_hit;
  logic ml_done_ff, ml_fail_ff, ml_any_ff, pl_reject_ff, auto_pend_ff, sp_ok_ff;
  logic [31:0] ctrl_ff, cmp_ff, dref_ff, cfg_ff, cons_ff, win_ff;
  logic [7:0] trace_idx_ff;
  logic [31:0] trace_mem [TRACE_DEPTH];
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  function automatic logic legal_addr(input logic [7:0] a);
    return a <= CMC_ADDR_CNT && a[1:0] == 2'b00;
  endfunction

  logic cmd_start, cmd_stop, cmd_uload, cmd_pload, cmd_pgup, cmd_pgdn, cmd_norm;
  assign cmd_start = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_START];
  assign cmd_stop = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_STOP];
  assign cmd_uload = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_ULOAD];
  assign cmd_pload = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_PLOAD];
  assign cmd_pgup = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_PGUP];
  assign cmd_pgdn = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_PGDN];
  assign cmd_norm = wr && paddr == CMC_ADDR_CMD && pwdata[CMC_K_NORMAL];

  // ==========================================================
  // control register; mck field kept legal: writes above CMC_MCK_LOGSTOP keep the old value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= 32'h0000_0000;
    else if (wr && paddr == CMC_ADDR_CTRL)
    begin
      ctrl_ff <= pwdata;
      if (!pwdata[CMC_C_SVC] && !ctrl_ff[CMC_C_SVC])
        ctrl_ff[CMC_C_STEP] <= ctrl_ff[CMC_C_STEP];
      if (pwdata[CMC_C_MCK_LO +: 3] > 3'(CMC_MCK_LOGSTOP))
        ctrl_ff[CMC_C_MCK_LO +: 3] <= ctrl_ff[CMC_C_MCK_LO +: 3];
    end
    else if (cmd_norm)
      ctrl_ff[CMC_C_STEP] <= 1'b0;
    else if (cmp_hit && ctrl_ff[CMC_C_ACONT])
      ctrl_ff[CMC_C_ACMP] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_ff <= 32'h0000_0000;
      dref_ff <= 32'h0000_0000;
    end
    else if (wr && paddr == CMC_ADDR_CMP)
      cmp_ff <= pwdata;
    else if (wr && paddr == CMC_ADDR_DREF)
      dref_ff <= pwdata;
  end

  // ==========================================================
  // compare logic
  assign src_ok = ctrl_ff[CMC_C_SRC_LO +: 3] == 3'(CMC_SRC_ANY)
    || ctrl_ff[CMC_C_SRC_LO +: 3] == 3'(cpu_ref.src);
  assign cmp_hit = ctrl_ff[CMC_C_ACMP] && cpu_ref.valid && src_ok
    && cpu_ref.virt == ctrl_ff[CMC_C_VIRT] && cpu_ref.addr == cmp_ff;
  assign data_hit = ctrl_ff[CMC_C_DCMP] && cpu_ref.valid && src_ok
    && cpu_ref.addr == cmp_ff && cpu_ref.data == dref_ff;

  // ==========================================================
  // run control
  logic step_wait_ff, pend_stop;
  assign pend_stop = (cmp_hit && !ctrl_ff[CMC_C_ACONT]) || data_hit;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_run_ff <= 1'b0;
      take_intr_ff <= 1'b0;
      step_wait_ff <= 1'b0;
    end
    else if (cmd_stop || pend_stop || (wr && paddr == CMC_ADDR_WIN))
    begin
      cpu_run_ff <= 1'b0;
      take_intr_ff <= 1'b0;
      step_wait_ff <= 1'b0;
    end
    else if (cmd_start && !cpu_run_ff && !take_intr_ff && ml_done_ff)
    begin
      cpu_run_ff <= 1'b1;
      step_wait_ff <= ctrl_ff[CMC_C_STEP];
    end
    else if (step_wait_ff && insn_done)
    begin
      cpu_run_ff <= 1'b0;
      step_wait_ff <= 1'b0;
      take_intr_ff <= intr_pending;
    end
    else if (take_intr_ff && (intr_taken || !intr_pending))
      take_intr_ff <= 1'b0;
  end

  // ==========================================================
  // trace buffer
  logic trace_on_d_ff, trace_full_ff;
  logic [TW-1:0] tptr_ff;
  logic trace_wr;
  assign trace_wr = ctrl_ff[CMC_C_TRACE] && trace_on_d_ff && cpu_ref.valid
    && cpu_ref.src == CMC_SRC_IC && !(trace_full_ff && !ctrl_ff[CMC_C_WRAP]);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trace_on_d_ff <= 1'b0;
      trace_full_ff <= 1'b0;
      tptr_ff <= '0;
    end
    else
    begin
      trace_on_d_ff <= ctrl_ff[CMC_C_TRACE];
      if (ctrl_ff[CMC_C_TRACE] && !trace_on_d_ff)
      begin
        tptr_ff <= '0;
        trace_full_ff <= 1'b0;
      end
      else if (trace_wr)
      begin
        tptr_ff <= (tptr_ff == TLAST) ? '0 : tptr_ff + 1'b1;
        if (tptr_ff == TLAST)
          trace_full_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk)
  begin
    if (trace_wr)
      trace_mem[tptr_ff] <= cpu_ref.addr;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trace_idx_ff <= 8'h00;
    else if (wr && paddr == CMC_ADDR_TRIDX && pwdata[7:0] <= 8'(TLAST))
      trace_idx_ff <= pwdata[7:0];
  end

  // ==========================================================
  // storage display window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_ff <= 32'h0000_0000;
    else if (wr && paddr == CMC_ADDR_WIN)
      win_ff <= pwdata & ~(CMC_WIN_STEP - 32'h1);
    else if (cmd_pgup && !cpu_run_ff)
      win_ff <= win_ff + CMC_WIN_STEP;
    else if (cmd_pgdn && !cpu_run_ff)
      win_ff <= win_ff - CMC_WIN_STEP;
  end

  // ==========================================================
  // load parameters and sequencing
  logic [7:0] ml_code_ff;
  logic cfg_bad;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_ff <= CMC_CFG_RST;
    else if (wr && paddr == CMC_ADDR_CFG)
      cfg_ff <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_pend_ff <= 1'b1;
      sp_ok_ff <= 1'b0;
      cpu_load_req_ff <= 1'b0;
      full_reset_ff <= 1'b0;
      keep_tod_reset_ff <= 1'b0;
      ml_any_ff <= 1'b0;
      ml_done_ff <= 1'b0;
      ml_fail_ff <= 1'b0;
      ml_code_ff <= 8'h00;
    end
    else
    begin
      full_reset_ff <= 1'b0;
      keep_tod_reset_ff <= 1'b0;
      cpu_load_req_ff <= 1'b0;
      if (sp_load.ok)
        sp_ok_ff <= 1'b1;
      if (sp_load.fail || cpu_load.fail)
      begin
        ml_fail_ff <= 1'b1;
        ml_code_ff <= sp_load.fail ? sp_load.code : cpu_load.code;
        auto_pend_ff <= 1'b0;
      end
      else if (cpu_load.ok)
      begin
        ml_done_ff <= 1'b1;
        ml_fail_ff <= 1'b0;
      end
      if ((sp_ok_ff && auto_pend_ff && cfg_ff[CMC_G_AUTO]) || (cmd_uload && sp_ok_ff))
      begin
        auto_pend_ff <= 1'b0;
        cpu_load_req_ff <= 1'b1;
        ml_any_ff <= 1'b1;
        ml_done_ff <= 1'b0;
        full_reset_ff <= !ml_any_ff;
        keep_tod_reset_ff <= ml_any_ff;
      end
      else if (sp_ok_ff && auto_pend_ff && !cfg_ff[CMC_G_AUTO])
        auto_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_load_req_ff <= 1'b0;
      prog_load_clear_ff <= 1'b0;
      prog_load_unit_ff <= '0;
      pl_reject_ff <= 1'b0;
    end
    else
    begin
      prog_load_req_ff <= 1'b0;
      if (cmd_pload && !ml_done_ff)
        pl_reject_ff <= 1'b1;
      else if (cmd_pload)
      begin
        pl_reject_ff <= 1'b0;
        prog_load_req_ff <= 1'b1;
        prog_load_clear_ff <= cfg_ff[CMC_G_CLEAR];
        prog_load_unit_ff <= cfg_ff[CMC_G_UNIT_LO +: CMC_UNIT_W];
      end
    end
  end

  // ==========================================================
  // console config: cons_ff holds one address per device slot
  function automatic int unsigned distinct_cnt(input logic [31:0] c);
    int unsigned n;
    n = 0;
    for (int i = 0; i < CMC_NCONS; i++)
    begin
      logic seen;
      seen = 1'b0;
      for (int j = 0; j < i; j++)
        if (c[j*CMC_ADDR_W +: CMC_ADDR_W] == c[i*CMC_ADDR_W +: CMC_ADDR_W])
          seen = 1'b1;
      if (!seen)
        n++;
    end
    return n;
  endfunction

  assign cfg_bad = cfg_ff[CMC_G_DISPM] ? (distinct_cnt(pwdata) != CMC_NCONS)
    : (distinct_cnt(pwdata) > CMC_PK_MAXADDR);
  logic cons_rej_ff, cons_fail_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cons_ff <= CMC_CONS_RST;
      cons_rej_ff <= 1'b0;
    end
    else if (wr && paddr == CMC_ADDR_CONS)
    begin
      cons_rej_ff <= cfg_bad;
      if (!cfg_bad)
        cons_ff <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_cons_ff <= 2'b00;
      cons_fail_ff <= 1'b0;
    end
    else if (!sp_ok_ff && sp_load.start && !cons_ok[primary_cons_ff])
    begin
      cons_fail_ff <= 1'b1;
      for (int k = CMC_NCONS - 1; k >= 1; k--)
        if (cons_ok[2'(primary_cons_ff + 2'(k))])
          primary_cons_ff <= 2'(primary_cons_ff + 2'(k));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mck_action_ff <= 3'(CMC_MCK_NORMAL);
    else
      mck_action_ff <= ctrl_ff[CMC_C_MCK_LO +: 3];
  end

  // ==========================================================
  // read path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      pslverr <= psel && !penable && !legal_addr(paddr);
      if (rd)
        unique case (paddr)
          CMC_ADDR_CTRL: prdata <= ctrl_ff;
          CMC_ADDR_CMP: prdata <= cmp_ff;
          CMC_ADDR_DREF: prdata <= dref_ff;
          CMC_ADDR_STAT: prdata <= {11'h0, cons_fail_ff, cons_rej_ff, trace_full_ff,
            ml_code_ff, 2'b00, primary_cons_ff, pl_reject_ff, ml_fail_ff, ml_done_ff,
            take_intr_ff, step_wait_ff, cpu_run_ff};
          CMC_ADDR_CFG: prdata <= cfg_ff;
          CMC_ADDR_CONS: prdata <= cons_ff;
          CMC_ADDR_WIN: prdata <= win_ff;
          CMC_ADDR_TRIDX: prdata <= {24'h0, trace_idx_ff};
          CMC_ADDR_TRDAT: prdata <= trace_mem[trace_idx_ff[TW-1:0]];
          CMC_ADDR_CNT: prdata <= {24'h0, 8'(tptr_ff)};
          default: prdata <= 32'h0000_0000;
        endcase
    end
  end

  // ==========================================================
  // checks
  step_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_wait_ff && insn_done && !cmd_stop && !pend_stop |=> !cpu_run_ff)
    else $error("step did not stop");
  pl_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_pload && !ml_done_ff |=> pl_reject_ff && !prog_load_req_ff)
    else $error("program load not rejected");
  trace_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    trace_full_ff && !ctrl_ff[CMC_C_WRAP] && trace_on_d_ff && ctrl_ff[CMC_C_TRACE]
      |=> $stable(tptr_ff))
    else $error("trace advanced when full");
  trace_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    trace_wr && tptr_ff == TLAST && !(ctrl_ff[CMC_C_TRACE] && !trace_on_d_ff)
      |=> tptr_ff == '0 && trace_full_ff)
    else $error("trace depth wrong");
  mck_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    mck_action_ff <= 3'(CMC_MCK_LOGSTOP))
    else $error("machine check action illegal");
  addr_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && !ctrl_ff[CMC_C_ACONT] |=> !cpu_run_ff)
    else $error("address match did not stop");
  data_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_hit |=> !cpu_run_ff)
    else $error("data match did not stop");
  first_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_load_req_ff |-> full_reset_ff != keep_tod_reset_ff)
    else $error("load reset kind wrong");
  win_page_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_pgup && !cpu_run_ff |=> win_ff == $past(win_ff) + CMC_WIN_STEP)
    else $error("page step wrong");
endmodule

// >>> tb/cmc_cpu_model.sv
`timescale 1ns/1ps
module cmc_cpu_model
  import cmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_run_ff,
  input wire logic take_intr_ff,
  input wire logic cpu_load_req_ff,
  input wire logic load_bad,
  input wire logic sp_go,
  input wire logic irq,
  input wire logic slow,
  output cmc_ref_t cpu_ref,
  output logic insn_done,
  output logic intr_pending,
  output logic intr_taken,
  output cmc_load_t sp_load,
  output cmc_load_t cpu_load
);
  // ==========================================================
  // fetch stream: one instruction at most every other cycle
  logic ph_ff;
  logic [31:0] pc_ff;
  logic [2:0] lc_ff;
  logic [2:0] sc_ff;
  logic fetch;
  // no new fetch while the last completion is still visible
  assign fetch = cpu_run_ff && !insn_done && (!slow || ph_ff);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_ff <= 1'b0;
      pc_ff <= 32'h0000_1000;
      lc_ff <= 3'h0;
      sc_ff <= 3'h0;
      cpu_ref <= '0;
      insn_done <= 1'b0;
      intr_pending <= 1'b0;
      intr_taken <= 1'b0;
      sp_load <= '0;
      cpu_load <= '0;
    end
    else
    begin
      ph_ff <= ~ph_ff;
      insn_done <= fetch;
      cpu_ref.valid <= fetch;
      cpu_ref.src <= CMC_SRC_IC;
      cpu_ref.virt <= 1'b0;
      // idle bus shows no stale address
      cpu_ref.addr <= fetch ? pc_ff : ~pc_ff;
      cpu_ref.data <= fetch ? pc_ff : ~pc_ff;
      if (fetch)
        pc_ff <= pc_ff + 32'h4;
      intr_taken <= take_intr_ff && intr_pending;
      if (irq)
        intr_pending <= 1'b1;
      else if (take_intr_ff)
        intr_pending <= 1'b0;
      lc_ff <= cpu_load_req_ff ? 3'h4 : (lc_ff != 3'h0 ? lc_ff - 3'h1 : 3'h0);
      sc_ff <= sp_go ? 3'h4 : (sc_ff != 3'h0 ? sc_ff - 3'h1 : 3'h0);
      cpu_load.start <= cpu_load_req_ff;
      cpu_load.ok <= (lc_ff == 3'h1) && !load_bad;
      cpu_load.fail <= (lc_ff == 3'h1) && load_bad;
      cpu_load.code <= (lc_ff == 3'h1) && load_bad ? 8'h5a : 8'h00;
      sp_load.start <= sp_go;
      sp_load.ok <= sc_ff == 3'h1;
    end
  end
endmodule

// >>> tb/console_maintenance_control_tb.sv
`timescale 1ns/1ps
module console_maintenance_control_tb;
  import cmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, p0;
  cmc_ref_t cpu_ref;
  cmc_load_t sp_load, cpu_load;
  logic insn_done, intr_pending, intr_taken, load_bad, sp_go, irq, slow;
  logic [3:0] cons_ok;
  logic run, take_i, full_r, tod_r, cl_req, pl_req, pl_clr;
  logic [11:0] pl_unit;
  logic [2:0] mck;
  logic [1:0] prim;
  int failures, num_checks, cyc, full_cnt, tod_cnt, req_cnt, pl_cnt, ins_cnt, it_cnt, trc_cnt;
  cmc_top #(.TRACE_DEPTH(168)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_ref(cpu_ref), .insn_done(insn_done),
    .intr_pending(intr_pending), .intr_taken(intr_taken), .sp_load(sp_load),
    .cpu_load(cpu_load), .cons_ok(cons_ok), .cpu_run_ff(run), .take_intr_ff(take_i),
    .full_reset_ff(full_r), .keep_tod_reset_ff(tod_r), .cpu_load_req_ff(cl_req),
    .prog_load_req_ff(pl_req), .prog_load_clear_ff(pl_clr), .prog_load_unit_ff(pl_unit),
    .mck_action_ff(mck), .primary_cons_ff(prim));
  cmc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_run_ff(run),
    .take_intr_ff(take_i), .cpu_load_req_ff(cl_req), .load_bad(load_bad), .sp_go(sp_go),
    .irq(irq), .slow(slow), .cpu_ref(cpu_ref), .insn_done(insn_done),
    .intr_pending(intr_pending), .intr_taken(intr_taken), .sp_load(sp_load),
    .cpu_load(cpu_load));
  // ==========================================================
  // clock, event counters and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    full_cnt += int'(full_r);
    tod_cnt += int'(tod_r);
    req_cnt += int'(cl_req);
    pl_cnt += int'(pl_req);
    ins_cnt += int'(insn_done);
    it_cnt += int'(intr_taken);
    trc_cnt += int'(cpu_ref.valid && cpu_ref.src == CMC_SRC_IC);
    if (cyc == 40000)
    begin
      failures++;
      complete_run();
    end
  end
  // ==========================================================
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input int b);
    wr(CMC_ADDR_CMD, 32'h1 << b);
  endtask
  task automatic stat_bit(input string nm, input int b, input logic v);
    rd(CMC_ADDR_STAT);
    chk(nm, {31'h0, v}, {31'h0, rdat[b]});
  endtask
  task automatic trd(input int i, input logic [31:0] e);
    wr(CMC_ADDR_TRIDX, 32'(i));
    rd(CMC_ADDR_TRDAT);
    chk("trace entry", e, rdat);
  endtask
  task automatic halt();
    int k;
    k = 0;
    cmd(CMC_K_STOP);
    while (run !== 1'b0 && k < 400)
    begin
      @(posedge pclk);
      k++;
    end
    chk("stopped", 32'h0, {31'h0, run});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(CMC_ADDR_CFG);
    chk("cfg reset", CMC_CFG_RST, rdat);
    rd(CMC_ADDR_CONS);
    chk("cons reset", 32'h0000_3210, rdat);
    rd(8'h2c);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    cmd(CMC_K_PLOAD);
    stat_bit("no load reject", 5, 1'b1);
    chk("pl refused", 32'h0, 32'(pl_cnt));
    $display("test reset done");
  endtask
  task automatic t_load();
    int f2;
    cons_ok <= 4'b1110;
    sp_go <= 1'b1;
    @(posedge pclk);
    sp_go <= 1'b0;
    wt(30);
    chk("primary moved", 32'h1, {30'h0, prim});
    stat_bit("cons failed", 20, 1'b1);
    chk("auto load", 32'h1, 32'(req_cnt));
    chk("first full", 32'h1, 32'(full_cnt));
    stat_bit("load failed", 4, 1'b1);
    chk("fail code", 32'h5a, {24'h0, rdat[17:10]});
    wt(30);
    chk("no retry", 32'h1, 32'(req_cnt));
    load_bad <= 1'b0;
    cmd(CMC_K_ULOAD);
    wt(20);
    stat_bit("load done", 3, 1'b1);
    f2 = full_cnt;
    cmd(CMC_K_ULOAD);
    wt(20);
    chk("later keeps tod", 32'(f2), 32'(full_cnt));
    chk("tod reset", 32'h2, 32'(tod_cnt));
    $display("test load done");
  endtask
  task automatic t_param();
    wr(CMC_ADDR_CFG, 32'h0000_1233);
    rd(CMC_ADDR_CFG);
    chk("cfg stored", 32'h0000_1233, rdat);
    chk("unit not yet", 32'h0, {20'h0, pl_unit});
    cmd(CMC_K_PLOAD);
    wt(2);
    chk("pl sent", 32'h1, 32'(pl_cnt));
    chk("pl unit", 32'h123, {20'h0, pl_unit});
    chk("pl clear", 32'h1, {31'h0, pl_clr});
    $display("test param done");
  endtask
  task automatic t_cons();
    wr(CMC_ADDR_CONS, 32'h0000_1100);
    stat_bit("two ok", 19, 1'b0);
    wr(CMC_ADDR_CONS, 32'h0000_2100);
    stat_bit("three refused", 19, 1'b1);
    rd(CMC_ADDR_CONS);
    chk("cons kept", 32'h0000_1100, rdat);
    wr(CMC_ADDR_CFG, 32'h0000_1237);
    wr(CMC_ADDR_CONS, 32'h0000_3210);
    wr(CMC_ADDR_CONS, 32'h0000_3310);
    stat_bit("dup refused", 19, 1'b1);
    rd(CMC_ADDR_CONS);
    chk("cons kept", 32'h0000_3210, rdat);
    $display("test cons done");
  endtask
  task automatic t_mck();
    for (int v = 0; v < 5; v++)
    begin
      wr(CMC_ADDR_CTRL, 32'(v) << CMC_C_MCK_LO);
      // action output lags the control write by one edge
      wt(1);
      chk("mck set", 32'(v), {29'h0, mck});
    end
    wr(CMC_ADDR_CTRL, 32'h0000_7000);
    wt(1);
    chk("mck kept", 32'h4, {29'h0, mck});
    $display("test mck done");
  endtask
  task automatic t_step();
    int i0;
    wr(CMC_ADDR_CTRL, 32'h0000_0020);
    rd(CMC_ADDR_CTRL);
    chk("step refused", 32'h0, {31'h0, rdat[CMC_C_STEP]});
    wr(CMC_ADDR_CTRL, 32'h0000_0060);
    irq <= 1'b1;
    @(posedge pclk);
    irq <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      i0 = ins_cnt;
      cmd(CMC_K_START);
      wt(20);
      chk("one insn", 32'h1, 32'(ins_cnt - i0));
      chk("restopped", 32'h0, {31'h0, run});
    end
    chk("intr taken", 32'h1, 32'(it_cnt));
    cmd(CMC_K_NORMAL);
    rd(CMC_ADDR_CTRL);
    chk("step cleared", 32'h0, {31'h0, rdat[CMC_C_STEP]});
    i0 = ins_cnt;
    cmd(CMC_K_START);
    wt(60);
    chk("full speed", 32'h1, 32'(ins_cnt - i0 > 20));
    halt();
    $display("test step done");
  endtask
  task automatic t_win();
    cmd(CMC_K_START);
    wt(5);
    wr(CMC_ADDR_WIN, 32'h0000_0213);
    wt(5);
    chk("display stops", 32'h0, {31'h0, run});
    rd(CMC_ADDR_WIN);
    chk("win aligned", 32'h0000_0200, rdat);
    cmd(CMC_K_PGUP);
    rd(CMC_ADDR_WIN);
    chk("page fwd", 32'h0000_0200 + CMC_WIN_STEP, rdat);
    cmd(CMC_K_PGDN);
    cmd(CMC_K_PGDN);
    rd(CMC_ADDR_WIN);
    chk("page back", 32'h0000_0200 - CMC_WIN_STEP, rdat);
    $display("test window done");
  endtask
  task automatic t_trace();
    int n;
    for (int w = 0; w < 2; w++)
    begin
      wr(CMC_ADDR_CTRL, 32'h0);
      wr(CMC_ADDR_CTRL, 32'(1 + 2 * w));
      rd(CMC_ADDR_CNT);
      chk("ptr restart", 32'h0, rdat);
      slow <= w[0];
      p0 = u_cpu.pc_ff;
      n = trc_cnt;
      cmd(CMC_K_START);
      wt(400 + 600 * w);
      halt();
      // let the last fetch be counted before reading the tally
      wt(2);
      n = trc_cnt - n;
      if (w == 0)
      begin
        stat_bit("trace full", 18, 1'b1);
        trd(0, p0);
        trd(167, p0 + 32'(4 * 167));
      end
      else
      begin
        rd(CMC_ADDR_CNT);
        chk("wrap ptr", 32'(n % 168), rdat);
        trd((n + 167) % 168, p0 + 32'(4 * (n - 1)));
        trd(n % 168, p0 + 32'(4 * (n - 168)));
      end
    end
    slow <= 1'b0;
    $display("test trace done");
  endtask
  task automatic t_cmp();
    int i0;
    for (int s = 0; s < 3; s++)
    begin
      wr(CMC_ADDR_CTRL, 32'h0);
      p0 = u_cpu.pc_ff;
      // data compare watches the data at the compare address
      wr(CMC_ADDR_CMP, s == 2 ? p0 + 32'h14 : p0 + 32'h28);
      wr(CMC_ADDR_DREF, p0 + 32'h14);
      wr(CMC_ADDR_CTRL, s == 2 ? 32'h0000_0110 : (s == 1 ? 32'h0000_0004 : 32'h0000_0104));
      i0 = ins_cnt;
      cmd(CMC_K_START);
      wt(60);
      i0 = ins_cnt - i0;
      chk("cmp stop", 32'h0, {31'h0, run});
      chk("stop point", 32'h1, 32'(s == 2 ? (i0 >= 6 && i0 <= 7) : (i0 >= 11 && i0 <= 12)));
    end
    wr(CMC_ADDR_CTRL, 32'h0);
    p0 = u_cpu.pc_ff;
    wr(CMC_ADDR_CMP, p0 + 32'h28);
    wr(CMC_ADDR_CTRL, 32'h0000_010c);
    cmd(CMC_K_START);
    wt(60);
    chk("continue", 32'h1, {31'h0, run});
    rd(CMC_ADDR_CTRL);
    chk("cmp off", 32'h0, {31'h0, rdat[CMC_C_ACMP]});
    halt();
    $display("test compare done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cons_ok = 4'hf;
    load_bad = 1'b1;
    sp_go = 1'b0;
    irq = 1'b0;
    slow = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_load();
    t_param();
    t_cons();
    t_mck();
    t_step();
    t_win();
    t_trace();
    t_cmp();
    complete_run();
  end
endmodule
